// file: hw/pcr_params.svh
// Offsets, field positions, reset values and counts of the power control block
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH
// Register indices; byte address is four times the index
`define PCR_PWR_IDX 10'h087
`define PCR_AUX_IDX 10'h088
`define PCR_STS_IDX 10'h089
`define PCR_MSK_IDX 10'h08A
// Power control reset values per cause
`define PCR_PWR_POR 8'h30
`define PCR_PWR_BOR 8'h20
`define PCR_PWR_OTH 8'h00
// Power control fields
`define PCR_B_BAUD 7
`define PCR_B_SEL 6
`define PCR_B_BRN 5
`define PCR_B_PON 4
`define PCR_B_PDN 1
`define PCR_B_SLP 0
`define PCR_AUX_LPM_BIT 4
`define PCR_CFG_RSEL_BIT 6
// Event bits of status and mask
`define PCR_EV_W 3
`define PCR_EV_BROWN 0
`define PCR_EV_PDW 1
`define PCR_EV_IDW 2
// Oscillator start-up and power-on reset hold counts in CPU clocks
`define PCR_CNT_W 11
`define PCR_WARM_XTAL 11'd1024
`define PCR_WARM_RC 11'd256
`define PCR_POR_W 8
`define PCR_POR_HOLD 8'd64
`endif

// file: hw/pcr_pkg.sv
// Types shared by the power control block
`include "pcr_params.svh"
package pcr_pkg;
    typedef enum logic [1:0] {PCR_RUN, PCR_IDLE, PCR_PDOWN, PCR_WARM} pcr_mode_t;

    typedef struct packed {
        logic [7:0] pwr;
        logic analog_off;
        logic rst_sel_done;
        logic rst_sel;
        pcr_mode_t mode;
        logic [`PCR_CNT_W-1:0] cnt;
        logic [`PCR_POR_W-1:0] por_cnt;
        logic [`PCR_EV_W-1:0] sts;
        logic [`PCR_EV_W-1:0] msk;
        logic bor_int_d;
        logic irq;
        logic cpu_rst_n;
        logic osc_en;
        logic cpu_halt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pcr_state_t;
endpackage

// file: hw/pcr_sync.sv
// Two-flop synchroniser for a group of levels from other domains
`timescale 1ns/1ps
`default_nettype none
module pcr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pcr_sync_t;

    pcr_sync_t st_r;
    pcr_sync_t st_nxt;

    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.s1 <= RST_VAL;
            st_r.s2 <= RST_VAL;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule // pcr_sync
`default_nettype wire

// file: hw/pcr_top.sv
// Power control register, reset causes and power reduction modes
//
// Contract
// - Memory analog off bit drives the analog shutdown output of the memory.
// - Memory analog off bit clears only on power-on reset.
// - Power control resets to 30H power-on, 20H brownout, 00H other resets.
// - Power control written only as a whole byte lane.
// - Bit 7 drives baud doubling to the serial port.
// - Bit 6 selects meaning of serial control bit 7.
// - Brownout flag set on brownout reset, interrupt and power-on; software clears.
// - Power-on flag set on power-on reset; software clears.
// - Bits 3 and 2 are plain user flags with no effect.
// - Writing bit 1 enters power-down; cleared when power-down ends.
// - Writing bit 0 enters idle; cleared when idle ends.
// - External reset input is active low when enabled.
// - Internal reset is generated on power-up without external signal.
// - Reset select at 0 ignores the external reset input.
// - Watchdog reset comes from its own oscillator domain.
// - Idle ends on enabled interrupt or any reset.
// - Power-down wake restarts oscillator; resume after 1024 or 256 clocks.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_params.svh"
module pcr_top
    import pcr_pkg::*;
#(
    parameter logic [`PCR_POR_W-1:0] POR_HOLD = `PCR_POR_HOLD
) (
    // Clock and power-on reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Reset sources and configuration
    input wire logic ext_reset_n,
    input wire logic brownout_reset,
    input wire logic brownout_intr,
    input wire logic watchdog_reset,
    input wire logic [7:0] config_byte_one,
    input wire logic osc_crystal,
    // Wake request from the interrupt controller
    input wire logic wake_irq,
    // Controls to the rest of the chip
    output logic memory_analog_off,
    output logic baud_double,
    output logic serial_bit7_select,
    output logic cpu_rst_n,
    output logic cpu_halt,
    output logic osc_enable,
    output logic irq
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] sync_q;
    logic bor_s;
    logic bint_s;
    logic ext_n_s;
    logic wdt_s;

    // Watchdog runs on its own oscillator, so its reset is crossed here
    pcr_sync #(.W(4), .RST_VAL(4'h4)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d({watchdog_reset, ext_reset_n, brownout_intr, brownout_reset}),
        .q(sync_q)
    );

    assign bor_s = sync_q[0];
    assign bint_s = sync_q[1];
    assign ext_n_s = sync_q[2];
    assign wdt_s = sync_q[3];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    pcr_state_t q_r;
    pcr_state_t q_nxt;

    logic acc_wr;
    logic wr_pwr;
    logic bor_ev;
    logic ext_rst;
    logic soft_rst;
    logic [`PCR_EV_W-1:0] ev;
    logic [`PCR_EV_W-1:0] clr;

    always_comb begin
        q_nxt = q_r;
        ev = '0;
        clr = '0;
        acc_wr = psel && penable && q_r.pready && pwrite && !q_r.pslverr;
        wr_pwr = acc_wr && paddr[11:2] == `PCR_PWR_IDX && pstrb[0];
        bor_ev = bint_s && !q_r.bor_int_d;
        ext_rst = q_r.rst_sel && !ext_n_s;
        soft_rst = bor_s || wdt_s || ext_rst;

        // Configuration is fetched once after power-on and frozen
        if (!q_r.rst_sel_done) begin
            q_nxt.rst_sel_done = 1'b1;
            q_nxt.rst_sel = config_byte_one[`PCR_CFG_RSEL_BIT];
        end

        // APB: data is prepared in setup so the access needs no wait state
        if (psel && !penable) begin
            q_nxt.pready = 1'b1;
            q_nxt.pslverr = 1'b0;
            q_nxt.prdata = 32'h0000_0000;
            unique case (paddr[11:2])
                `PCR_PWR_IDX: q_nxt.prdata[7:0] = q_r.pwr;
                `PCR_AUX_IDX: q_nxt.prdata[`PCR_AUX_LPM_BIT] = q_r.analog_off;
                `PCR_STS_IDX: q_nxt.prdata[`PCR_EV_W-1:0] = q_r.sts;
                `PCR_MSK_IDX: q_nxt.prdata[`PCR_EV_W-1:0] = q_r.msk;
                default: q_nxt.pslverr = 1'b1;
            endcase
        end else if (psel && penable && q_r.pready) begin
            q_nxt.pready = 1'b0;
        end

        if (wr_pwr) begin
            q_nxt.pwr = pwdata[7:0];
        end
        if (acc_wr && paddr[11:2] == `PCR_AUX_IDX && pstrb[0]) begin
            // Only a set is accepted; clearing takes a power-on reset
            q_nxt.analog_off = q_r.analog_off | pwdata[`PCR_AUX_LPM_BIT];
        end
        if (acc_wr && paddr[11:2] == `PCR_STS_IDX && pstrb[0]) begin
            clr = pwdata[`PCR_EV_W-1:0];
        end
        if (acc_wr && paddr[11:2] == `PCR_MSK_IDX && pstrb[0]) begin
            q_nxt.msk = pwdata[`PCR_EV_W-1:0];
        end

        // Brownout interrupt sets the flag; set wins over a software clear
        q_nxt.bor_int_d = bint_s;
        if (bor_ev) begin
            q_nxt.pwr[`PCR_B_BRN] = 1'b1;
            ev[`PCR_EV_BROWN] = 1'b1;
        end

        // ------------------------------------------------------------
        // Power reduction modes
        // ------------------------------------------------------------
        unique case (q_r.mode)
            PCR_RUN: begin
                // Power-down wins when both bits are written together
                if (q_r.pwr[`PCR_B_PDN]) begin
                    q_nxt.mode = PCR_PDOWN;
                end else if (q_r.pwr[`PCR_B_SLP]) begin
                    q_nxt.mode = PCR_IDLE;
                end
            end
            PCR_IDLE: begin
                if (wake_irq) begin
                    q_nxt.mode = PCR_RUN;
                    q_nxt.pwr[`PCR_B_SLP] = 1'b0;
                    ev[`PCR_EV_IDW] = 1'b1;
                end
            end
            PCR_PDOWN: begin
                if (wake_irq) begin
                    q_nxt.mode = PCR_WARM;
                    q_nxt.pwr[`PCR_B_PDN] = 1'b0;
                    q_nxt.cnt = (osc_crystal ? `PCR_WARM_XTAL : `PCR_WARM_RC)
                        - `PCR_CNT_W'(1);
                    ev[`PCR_EV_PDW] = 1'b1;
                end
            end
            PCR_WARM: begin
                if (q_r.cnt == '0) begin
                    q_nxt.mode = PCR_RUN;
                end else begin
                    q_nxt.cnt = q_r.cnt - `PCR_CNT_W'(1);
                end
            end
        endcase

        // ------------------------------------------------------------
        // Reset causes other than power-on
        // ------------------------------------------------------------
        if (q_r.por_cnt != '0) begin
            q_nxt.por_cnt = q_r.por_cnt - `PCR_POR_W'(1);
        end
        if (soft_rst) begin
            // Any reset ends idle and power-down; memory analog bit is kept
            q_nxt.mode = PCR_RUN;
            q_nxt.cnt = '0;
            q_nxt.pwr = bor_s ? `PCR_PWR_BOR : `PCR_PWR_OTH;
        end

        q_nxt.sts = (q_r.sts & ~clr) | ev;
        q_nxt.irq = |(q_nxt.sts & q_nxt.msk);
        q_nxt.cpu_rst_n = !(soft_rst || q_nxt.por_cnt != '0);
        q_nxt.osc_en = q_nxt.mode != PCR_PDOWN;
        q_nxt.cpu_halt = q_nxt.mode != PCR_RUN;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= '0;
            q_r.pwr <= `PCR_PWR_POR;
            q_r.por_cnt <= POR_HOLD;
            q_r.osc_en <= 1'b1;
            q_r.cpu_halt <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign pready = q_r.pready;
    assign prdata = q_r.prdata;
    assign pslverr = q_r.pslverr;
    assign memory_analog_off = q_r.analog_off;
    assign baud_double = q_r.pwr[`PCR_B_BAUD];
    assign serial_bit7_select = q_r.pwr[`PCR_B_SEL];
    assign cpu_rst_n = q_r.cpu_rst_n;
    assign cpu_halt = q_r.cpu_halt;
    assign osc_enable = q_r.osc_en;
    assign irq = q_r.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_analog_sticky: assert property (q_r.analog_off |=> q_r.analog_off)
        else $error("memory analog off bit cleared without power-on reset");
    a_por_value: assert property (!q_r.rst_sel_done |-> q_r.pwr == `PCR_PWR_POR)
        else $error("power control not 30H after power-on reset");
    a_bor_value: assert property (bor_s |=> q_r.pwr == `PCR_PWR_BOR)
        else $error("power control not 20H after brownout reset");
    a_other_value: assert property (soft_rst && !bor_s |=> q_r.pwr == `PCR_PWR_OTH)
        else $error("power control not 00H after other reset");
    a_lane_ignored: assert property (acc_wr && paddr[11:2] == `PCR_PWR_IDX && !pstrb[0]
        && !soft_rst |=> $stable(q_r.pwr[3:2]))
        else $error("power control changed by partial write");
    a_user_flags: assert property (wr_pwr && !soft_rst
        |=> q_r.pwr[3:2] == $past(pwdata[3:2]))
        else $error("user flags not written");
    a_bof_set: assert property (bor_ev |=> q_r.pwr[`PCR_B_BRN])
        else $error("brownout flag not set");
    a_pd_enter: assert property (q_r.mode == PCR_RUN && q_r.pwr[`PCR_B_PDN] && !soft_rst
        |=> q_r.mode == PCR_PDOWN ##0 !osc_enable)
        else $error("power-down not entered");
    a_idle_exit: assert property (q_r.mode == PCR_IDLE && wake_irq
        |=> q_r.mode == PCR_RUN && !q_r.pwr[`PCR_B_SLP])
        else $error("idle not left on wake");
    a_warm_xtal: assert property (q_r.mode == PCR_PDOWN && wake_irq && osc_crystal && !soft_rst
        |=> q_r.cnt == `PCR_WARM_XTAL - `PCR_CNT_W'(1) ##0 cpu_halt)
        else $error("crystal start-up count wrong");
    a_warm_end: assert property (q_r.mode == PCR_WARM && q_r.cnt == '0 && !soft_rst
        |=> !cpu_halt)
        else $error("execution not resumed after start-up");
    a_ext_ignored: assert property (!q_r.rst_sel && !bor_s && !wdt_s && q_r.por_cnt == '0
        |=> cpu_rst_n)
        else $error("external reset not ignored");
    a_irq_level: assert property (irq == |(q_r.sts & q_r.msk))
        else $error("interrupt output differs from masked status");

    c_pd_wake: cover property (q_r.mode == PCR_WARM ##1 q_r.mode == PCR_RUN);
    c_idle: cover property (q_r.mode == PCR_IDLE ##1 q_r.mode == PCR_RUN);
    c_brownout: cover property (bor_ev);
    c_por_done: cover property ($rose(cpu_rst_n));
endmodule // pcr_top
`default_nettype wire

// file: sim/pcr_far.sv
// Interrupt-side model that wakes the halted core a fixed time after it stops
`timescale 1ns/1ps
`default_nettype none
module pcr_far #(
    parameter int DLY = 8
) (
    // Clock
    input wire logic sys_clk,
    // From the block
    input wire logic cpu_halt,
    // Wake request
    output logic wake_irq
);
    int cnt = 0;
    initial wake_irq = 1'b0;
    // One-cycle pulse: a lingering request would end the next sleep at once
    always @(posedge sys_clk) begin
        cnt <= (cpu_halt === 1'b1) ? cnt + 1 : 0;
        wake_irq <= (cpu_halt === 1'b1) && (cnt == DLY);
    end
endmodule // pcr_far
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the power control block
`timescale 1ns/1ps
`default_nettype none
`include "pcr_params.svh"
module tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic ext_reset_n, brownout_reset, brownout_intr, watchdog_reset, osc_crystal, wake_irq;
    logic [7:0] config_byte_one;
    logic memory_analog_off, baud_double, serial_bit7_select, cpu_rst_n, cpu_halt;
    logic osc_enable, irq;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;
    localparam logic [11:0] A_PWR = {`PCR_PWR_IDX, 2'b00};
    localparam logic [11:0] A_AUX = {`PCR_AUX_IDX, 2'b00};
    localparam logic [11:0] A_STS = {`PCR_STS_IDX, 2'b00};
    localparam logic [11:0] A_MSK = {`PCR_MSK_IDX, 2'b00};

    pcr_top #(.POR_HOLD(8'd4)) pcr_top_inst (
        .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .ext_reset_n, .brownout_reset, .brownout_intr,
        .watchdog_reset, .config_byte_one, .osc_crystal, .wake_irq,
        .memory_analog_off, .baud_double, .serial_bit7_select, .cpu_rst_n,
        .cpu_halt, .osc_enable, .irq
    );
    pcr_far pcr_far_inst (.sys_clk, .cpu_halt, .wake_irq);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Called right after a rising edge; an idle edge follows each transfer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask

    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'hF);
        chk(nm, exp, q);
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    task automatic close_out;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            $display("[FAIL] run_time expected end seen cycle limit");
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, brownout_reset, brownout_intr, watchdog_reset} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        ext_reset_n = 1'b1;
        osc_crystal = 1'b1;
        config_byte_one = 8'h40;
        tick(4);
        rst_n <= 1'b1;
        tick(8);
        chk("cpu_rst_n", 1, {31'h0, cpu_rst_n});
        rd("pwr_por", A_PWR, 32'h30);
        chk("analog_off", 0, {31'h0, memory_analog_off});
        wr(A_PWR, 32'hC0);
        chk("baud_double", 1, {31'h0, baud_double});
        chk("bit7_select", 1, {31'h0, serial_bit7_select});
        rd("pwr_c0", A_PWR, 32'hC0);
        apb(1'b1, A_PWR, 32'h0C, 4'h0);
        rd("pwr_nostrb", A_PWR, 32'hC0);
        wr(A_PWR, 32'h0C);
        rd("pwr_flags", A_PWR, 32'h0C);
        chk("baud_off", 0, {31'h0, baud_double});
        rd("unmapped", 12'h3FC, 32'h0);
        chk("slverr", 1, {31'h0, e});
        wr(A_MSK, 32'h7);
        wr(A_PWR, 32'h0D);
        // Mode follows the register one edge later
        tick(1);
        chk("idle_halt", 1, {31'h0, cpu_halt});
        while (cpu_halt !== 1'b0) @(posedge sys_clk);
        tick(1);
        rd("pwr_idle", A_PWR, 32'h0C);
        rd("status_idle", A_STS, 32'h4);
        chk("irq_on", 1, {31'h0, irq});
        wr(A_STS, 32'h4);
        chk("irq_off", 0, {31'h0, irq});
        for (int k = 0; k < 2; k++) begin
            osc_crystal <= ~k[0];
            wr(A_PWR, 32'h0E);
            tick(1);
            chk("osc_stop", 0, {31'h0, osc_enable});
            while (osc_enable !== 1'b1) @(posedge sys_clk);
            n = 0;
            while (cpu_halt === 1'b1) begin
                n++;
                @(posedge sys_clk);
            end
            chk("warm_cycles", k ? 256 : 1024, n);
            rd("pwr_pd", A_PWR, 32'h0C);
            rd("status_pd", A_STS, 32'h2);
            wr(A_STS, 32'h2);
        end
        brownout_intr <= 1'b1;
        tick(4);
        brownout_intr <= 1'b0;
        tick(4);
        rd("pwr_brown", A_PWR, 32'h2C);
        rd("status_bo", A_STS, 32'h1);
        wr(A_MSK, 32'h6);
        chk("irq_masked", 0, {31'h0, irq});
        wr(A_MSK, 32'h7);
        chk("irq_unmasked", 1, {31'h0, irq});
        wr(A_STS, 32'h1);
        wr(A_AUX, 32'h10);
        chk("analog_on", 1, {31'h0, memory_analog_off});
        wr(A_AUX, 32'h0);
        // Watchdog, brownout and pin resets in turn
        for (int s = 0; s < 3; s++) begin
            watchdog_reset <= (s == 0);
            brownout_reset <= (s == 1);
            ext_reset_n <= (s != 2);
            tick(6);
            chk("soft_cpu_rst", 0, {31'h0, cpu_rst_n});
            watchdog_reset <= 1'b0;
            brownout_reset <= 1'b0;
            ext_reset_n <= 1'b1;
            tick(12);
            chk("analog_kept", 1, {31'h0, memory_analog_off});
            rd("pwr_soft", A_PWR, (s == 1) ? 32'h20 : 32'h00);
        end
        // Power-on reset with the pin disabled by configuration
        config_byte_one <= 8'h00;
        rst_n <= 1'b0;
        tick(4);
        rst_n <= 1'b1;
        tick(2);
        chk("por_stretch", 0, {31'h0, cpu_rst_n});
        tick(8);
        chk("analog_por", 0, {31'h0, memory_analog_off});
        ext_reset_n <= 1'b0;
        tick(6);
        ext_reset_n <= 1'b1;
        tick(4);
        rd("pwr_pin_off", A_PWR, 32'h30);
        close_out();
    end
endmodule // tb
`default_nettype wire
